// file: verilog/cgm_pkg.sv
// constants for the clock generator mode control block
package cgm_pkg;
    localparam int unsigned ADDR_W        = 2;
    localparam logic [1:0]  OFS_CTRL1     = 2'h0;
    localparam logic [1:0]  OFS_STATUS    = 2'h1;
    localparam logic [1:0]  OFS_CTRLX     = 2'h2;
    localparam int unsigned BIT_HGO       = 7;
    localparam int unsigned BIT_RANGE     = 6;
    localparam int unsigned BIT_EXT_REF_SEL      = 5;
    localparam int unsigned BIT_MODE_HI   = 4;
    localparam int unsigned BIT_MODE_LO   = 3;
    localparam int unsigned BIT_KEEP      = 2;
    localparam int unsigned BIT_LOSS_CLK_DETECT_DIS      = 1;
    localparam int unsigned ST_MODE_HI    = 7;
    localparam int unsigned ST_MODE_LO    = 6;
    localparam int unsigned ST_REF_SOURCE_STATUS      = 5;
    localparam int unsigned ST_EXT_REF_CLK_STATUS       = 4;
    localparam int unsigned ST_BUSY       = 3;
    localparam int unsigned CX_ENABLE     = 0;
    localparam int unsigned CX_OFF        = 1;
    localparam logic [7:0]  CTRL1_RESET   = 8'h00;
    localparam logic [1:0]  MODE_SCM      = 2'h0;
    localparam logic [1:0]  MODE_FEI      = 2'h1;
    localparam logic [1:0]  MODE_FBE      = 2'h2;
    localparam logic [1:0]  MODE_FEE      = 2'h3;
    localparam logic [6:0]  PRESCALE_LOW  = 7'h40;
    localparam logic [6:0]  PRESCALE_HIGH = 7'h01;
    localparam int unsigned SYNC_STAGES   = 3;
endpackage

// file: verilog/cgm_sync.sv
// multi-stage level synchroniser for the mode status crossing
`timescale 1ns/1ps
module cgm_sync #(
    parameter int unsigned WIDTH  = 2,
    parameter int unsigned STAGES = 3
) (
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] stage_q [STAGES];

    genvar g;
    generate
        for (g = 0; g < STAGES; g++) begin : g_stage
            if (g == 0) begin : g_first
                always_ff @(posedge clk_in or negedge resetn_in) begin
                    if (!resetn_in) begin
                        stage_q[g] <= '0;
                    end else begin
                        stage_q[g] <= d_in;
                    end
                end
            end else begin : g_next
                always_ff @(posedge clk_in or negedge resetn_in) begin
                    if (!resetn_in) begin
                        stage_q[g] <= '0;
                    end else begin
                        stage_q[g] <= stage_q[g-1];
                    end
                end
            end
        end
    endgenerate

    assign q_out = stage_q[STAGES-1];
endmodule

// file: verilog/cgm_mode_ctrl.sv
// clock generator control register 1 with mode switching and pin control
`timescale 1ns/1ps
module cgm_mode_ctrl (
    input  wire logic                       clk_in,
    input  wire logic                       resetn_in,
    input  wire logic [cgm_pkg::ADDR_W-1:0] avs_address_in,
    input  wire logic                       avs_read_in,
    input  wire logic                       avs_write_in,
    input  wire logic [7:0]                 avs_writedata_in,
    output logic      [7:0]                 avs_readdata_out,
    output logic                            avs_waitrequest_out,
    input  wire logic                       ext_ref_ok_in,
    input  wire logic                       enable_in,
    input  wire logic                       off_mode_in,
    input  wire logic                       ref_in_pin_in,
    output logic                            osc_out_pin_out,
    output logic                            osc_out_pin_oe_n_out,
    output logic                            ext_ref_clock_out,
    output logic                            osc_enable_out,
    output logic                            osc_high_gain_out,
    output logic                            osc_high_range_out,
    output logic      [6:0]                 prescale_out,
    output logic                            loss_clk_detect_en_out,
    output logic      [1:0]                 active_mode_out
);
    typedef enum logic [2:0] {
        CGM_IDLE   = 3'h1,
        CGM_WAIT   = 3'h2,
        CGM_SETTLE = 3'h4
    } cgm_state_e;

    cgm_state_e state_q, state_d;
    logic [7:0] ctrl_q;
    logic       first_done_q;
    logic       pins_rsv_q;
    logic [1:0] req_mode_q;
    logic [1:0] act_mode_q;
    logic [1:0] act_mode_d;
    logic       rd_q;
    logic [7:0] rdata_q;
    logic [1:0] stat_mode;
    logic       ctrlx_enable_q;
    logic       ctrlx_off_q;

    // single-cycle writes; reads answer one cycle later from a register
    wire        wr_ctrl1   = avs_write_in && (avs_address_in == cgm_pkg::OFS_CTRL1);
    wire        wr_ctrlx   = avs_write_in && (avs_address_in == cgm_pkg::OFS_CTRLX);
    wire        rd_pend    = avs_read_in && !rd_q;
    wire [1:0]  wr_mode    = avs_writedata_in[cgm_pkg::BIT_MODE_HI:cgm_pkg::BIT_MODE_LO];
    wire        wr_ext     = wr_mode[1];
    wire        busy       = (state_q != CGM_IDLE);
    wire        mode_block = first_done_q && !pins_rsv_q && wr_ext;
    wire        mode_take  = wr_ctrl1 && !busy && !mode_block;
    wire        once_take  = wr_ctrl1 && !first_done_q;
    wire        ext_mode   = act_mode_q[1];
    wire        high_gain_sel        = ctrl_q[cgm_pkg::BIT_HGO];
    wire        rng        = ctrl_q[cgm_pkg::BIT_RANGE];
    wire        ext_ref_sel       = ctrl_q[cgm_pkg::BIT_EXT_REF_SEL];
    wire        keep       = ctrl_q[cgm_pkg::BIT_KEEP];
    wire        keep_ign   = high_gain_sel && rng;
    wire        ref_st     = ext_ref_sel;
    wire        rng_eff    = rng && ext_mode;
    wire        keep_run   = keep && req_mode_q[1] && ref_st && ext_ref_ok_in;
    wire        zero_run   = enable_in && (req_mode_q == cgm_pkg::MODE_FBE) && ref_st;
    wire        off_run    = (keep && !keep_ign) ? keep_run : zero_run;
    wire        osc_used   = pins_rsv_q && ext_ref_sel;
    wire        mode_done  = (req_mode_q != cgm_pkg::MODE_FBE) || ext_ref_ok_in;
    wire        off_eff    = off_mode_in || ctrlx_off_q;

    assign avs_waitrequest_out = rd_pend;
    assign avs_readdata_out    = rdata_q;

    always_comb begin
        state_d    = state_q;
        act_mode_d = act_mode_q;
        unique case (state_q)
            CGM_IDLE: begin
                if (mode_take && (wr_mode != act_mode_q)) begin
                    state_d = CGM_WAIT;
                end
            end
            CGM_WAIT: begin
                if (mode_done) begin
                    act_mode_d = req_mode_q;
                    state_d    = CGM_SETTLE;
                end
            end
            CGM_SETTLE: begin
                if (stat_mode == act_mode_q) begin
                    state_d = CGM_IDLE;
                end
            end
            default: begin
                state_d = CGM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q    <= CGM_IDLE;
            act_mode_q <= cgm_pkg::MODE_SCM;
        end else begin
            state_q    <= state_d;
            act_mode_q <= act_mode_d;
        end
    end

    // write-once bits and pin reservation latch on the very first write
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            first_done_q <= 1'b0;
            pins_rsv_q   <= 1'b0;
        end else if (once_take) begin
            first_done_q <= 1'b1;
            pins_rsv_q   <= wr_ext;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl_q[cgm_pkg::BIT_HGO:cgm_pkg::BIT_EXT_REF_SEL] <= cgm_pkg::CTRL1_RESET[cgm_pkg::BIT_HGO:cgm_pkg::BIT_EXT_REF_SEL];
        end else if (once_take) begin
            ctrl_q[cgm_pkg::BIT_HGO:cgm_pkg::BIT_EXT_REF_SEL] <= avs_writedata_in[cgm_pkg::BIT_HGO:cgm_pkg::BIT_EXT_REF_SEL];
        end
    end

    // mode field untouched by off mode; only a taken write changes it
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            req_mode_q <= cgm_pkg::MODE_SCM;
        end else if (mode_take) begin
            req_mode_q <= wr_mode;
        end
    end

    assign ctrl_q[cgm_pkg::BIT_MODE_HI:cgm_pkg::BIT_MODE_LO] = req_mode_q;
    assign ctrl_q[0] = 1'b0;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl_q[cgm_pkg::BIT_KEEP:cgm_pkg::BIT_LOSS_CLK_DETECT_DIS] <= cgm_pkg::CTRL1_RESET[cgm_pkg::BIT_KEEP:cgm_pkg::BIT_LOSS_CLK_DETECT_DIS];
        end else if (wr_ctrl1) begin
            ctrl_q[cgm_pkg::BIT_KEEP:cgm_pkg::BIT_LOSS_CLK_DETECT_DIS] <= avs_writedata_in[cgm_pkg::BIT_KEEP:cgm_pkg::BIT_LOSS_CLK_DETECT_DIS];
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrlx_enable_q <= 1'b0;
            ctrlx_off_q    <= 1'b0;
        end else if (wr_ctrlx) begin
            ctrlx_enable_q <= avs_writedata_in[cgm_pkg::CX_ENABLE];
            ctrlx_off_q    <= avs_writedata_in[cgm_pkg::CX_OFF];
        end
    end

    // status crosses via a synchroniser so it lags the active mode
    cgm_sync #(
        .WIDTH  (2),
        .STAGES (cgm_pkg::SYNC_STAGES)
    ) u_sync (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .d_in      (act_mode_q),
        .q_out     (stat_mode)
    );

    wire [7:0] status_word = {stat_mode, ref_st, ext_ref_ok_in, busy, 3'h0};
    wire [7:0] ctrlx_word  = {6'h00, ctrlx_off_q, ctrlx_enable_q};
    wire [7:0] rd_mux      = (avs_address_in == cgm_pkg::OFS_CTRL1)  ? ctrl_q :
                             (avs_address_in == cgm_pkg::OFS_STATUS) ? status_word :
                             (avs_address_in == cgm_pkg::OFS_CTRLX)  ? ctrlx_word : 8'h00;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_q    <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            rd_q <= rd_pend;
            if (rd_pend) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // oscillator and pin control, registered for clean outputs
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            osc_out_pin_out        <= 1'b0;
            osc_out_pin_oe_n_out   <= 1'b1;
            ext_ref_clock_out      <= 1'b0;
            osc_enable_out         <= 1'b0;
            osc_high_gain_out      <= 1'b0;
            osc_high_range_out     <= 1'b0;
            prescale_out           <= cgm_pkg::PRESCALE_LOW;
            loss_clk_detect_en_out <= 1'b0;
            active_mode_out        <= cgm_pkg::MODE_SCM;
        end else begin
            osc_out_pin_out        <= osc_used && osc_enable_out && !ref_in_pin_in;
            osc_out_pin_oe_n_out   <= !pins_rsv_q;
            ext_ref_clock_out      <= pins_rsv_q && ref_in_pin_in;
            osc_enable_out         <= osc_used && (!off_eff || off_run || ctrlx_enable_q && zero_run);
            osc_high_gain_out      <= high_gain_sel;
            osc_high_range_out     <= rng_eff;
            prescale_out           <= rng_eff ? cgm_pkg::PRESCALE_HIGH : cgm_pkg::PRESCALE_LOW;
            loss_clk_detect_en_out <= ext_mode && !ctrl_q[cgm_pkg::BIT_LOSS_CLK_DETECT_DIS];
            active_mode_out        <= act_mode_q;
        end
    end

    AST_BLOCK_1X: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (first_done_q && !pins_rsv_q) |-> !req_mode_q[1]) else $error("1X mode after 0X first write");
    AST_ONCE: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (wr_ctrl1 && first_done_q) |=> $stable(ctrl_q[7:5])) else $error("write-once bits changed");
    AST_FBE_WAIT: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (state_q == CGM_WAIT && req_mode_q == cgm_pkg::MODE_FBE && !ext_ref_ok_in) |=>
        (act_mode_q == $past(act_mode_q))) else $error("bypass taken without reference");
    AST_BUSY_DROP: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (wr_ctrl1 && busy) |=> $stable(req_mode_q)) else $error("mode write taken while busy");
    AST_PRESCALE: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (rng && ext_mode) |=> (prescale_out == cgm_pkg::PRESCALE_HIGH)) else $error("prescale wrong");
    AST_RANGE_INT: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !ext_mode |=> !osc_high_range_out) else $error("range active in internal mode");
    AST_PINS_FREE: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !pins_rsv_q |=> (osc_out_pin_oe_n_out && !ext_ref_clock_out)) else $error("pins used");
    AST_GAIN: assert property (@(posedge clk_in) disable iff (!resetn_in)
        1'b1 |=> (osc_high_gain_out == $past(high_gain_sel))) else $error("gain output wrong");
    AST_LOSS_CLK_DETECT_DIS: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ctrl_q[cgm_pkg::BIT_LOSS_CLK_DETECT_DIS] |=> !loss_clk_detect_en_out) else $error("detect not suppressed");
    AST_STATUS: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $changed(act_mode_q) |-> ##3 (stat_mode == $past(act_mode_q, 3))) else $error("status lag wrong");
endmodule

// file: verif/cgm_ref_model.sv
// external reference source: clock on the pin, valid flag after start-up
`timescale 1ns/1ps
module cgm_ref_model (
    input  wire logic       clk_in,
    input  wire logic       run_in,
    input  wire logic [3:0] startup_in,
    output logic            ref_pin_out,
    output logic            ref_ok_out
);
    logic [3:0] cnt_q;
    initial begin
        ref_pin_out = 1'b0;
        ref_ok_out = 1'b0;
        cnt_q = 4'h0;
    end
    // a stopped source holds its pin still and loses its valid flag at once
    always @(posedge clk_in) begin
        if (!run_in) begin
            cnt_q <= 4'h0;
            ref_ok_out <= 1'b0;
        end else begin
            ref_pin_out <= ~ref_pin_out;
            if (cnt_q != startup_in) cnt_q <= cnt_q + 4'h1;
            ref_ok_out <= (cnt_q == startup_in);
        end
    end
endmodule

// file: verif/clock_gen_mode_control_test.sv
// self-checking bench for the clock generator mode control block
`timescale 1ns/1ps
module clock_gen_mode_control_test;
    logic                       clk_in = 1'b0;
    logic                       resetn_in = 1'b0;
    logic [cgm_pkg::ADDR_W-1:0] avs_address_in = 2'h0;
    logic                       avs_read_in = 1'b0;
    logic                       avs_write_in = 1'b0;
    logic [7:0]                 avs_writedata_in = 8'h00;
    logic [7:0]                 avs_readdata_out;
    logic                       avs_waitrequest_out;
    logic                       enable_in = 1'b0;
    logic                       off_mode_in = 1'b0;
    logic                       run = 1'b0;
    logic [3:0]                 startup = 4'hf;
    logic                       ref_pin, ref_ok, seen_ext, pin_out, oe_n, ext_clk, osc_en, gain, rng, lcd;
    logic                       seen_osc;
    logic [6:0]                 prescale;
    logic [1:0]                 mode;
    logic [7:0]                 pins, rd, x;
    logic [15:0]                e;
    logic [15:0]                exp_q[$];
    int                         num_errors = 0;
    int                         num_checks = 0;
    int                         seed = 32'hd8cadfc5;
    initial forever #2 clk_in = ~clk_in;
    assign pins = {oe_n, gain, rng, osc_en, lcd, 1'b0, mode};
    cgm_ref_model partner (.clk_in(clk_in), .run_in(run), .startup_in(startup), .ref_pin_out(ref_pin),
        .ref_ok_out(ref_ok));
    cgm_mode_ctrl uut (.clk_in(clk_in), .resetn_in(resetn_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .ext_ref_ok_in(ref_ok), .enable_in(enable_in), .off_mode_in(off_mode_in), .ref_in_pin_in(ref_pin),
        .osc_out_pin_out(pin_out), .osc_out_pin_oe_n_out(oe_n), .ext_ref_clock_out(ext_clk),
        .osc_enable_out(osc_en), .osc_high_gain_out(gain), .osc_high_range_out(rng), .prescale_out(prescale),
        .loss_clk_detect_en_out(lcd), .active_mode_out(mode));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (num_errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // reads note {mask, expected}; the watcher below does the compare
    task automatic bus(input logic wr, input logic [1:0] adr, input logic [7:0] dat, input logic [7:0] msk);
        int n;
        @(posedge clk_in);
        avs_address_in <= adr;
        avs_writedata_in <= dat;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        if (!wr) exp_q.push_back({msk, dat});
        for (n = 0; n < 20; n++) begin
            @(posedge clk_in);
            if (avs_waitrequest_out === 1'b0) break;
        end
        if (n == 20) begin
            num_errors++;
            give_verdict();
        end
        rd = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask
    always @(posedge clk_in) begin
        if (avs_read_in && avs_waitrequest_out === 1'b0 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check(avs_readdata_out & e[15:8], e[7:0] & e[15:8]);
        end
        if (ext_clk === 1'b1) seen_ext = 1'b1;
        if (pin_out === 1'b1) seen_osc = 1'b1;
    end
    // busy clears only once the synchronised status has caught up
    task automatic settle();
        int n;
        for (n = 0; n < 40; n++) begin
            bus(1'b0, 2'h1, 8'h00, 8'h00);
            if (rd[3] === 1'b0) break;
        end
        if (n == 40) begin
            num_errors++;
            give_verdict();
        end
        repeat (4) @(posedge clk_in);
    endtask
    task automatic do_reset();
        @(posedge clk_in);
        resetn_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        resetn_in <= 1'b1;
        seen_ext = 1'b0;
        seen_osc = 1'b0;
    endtask
    initial begin
        do_reset();
        check(pins, 8'h80);
        check({1'b0, prescale}, 8'h40);
        bus(1'b0, 2'h3, 8'h00, 8'hff);
        bus(1'b1, 2'h0, 8'hfa, 8'h00);
        settle();
        check(pins, 8'h73);
        check({1'b0, prescale}, 8'h01);
        bus(1'b0, 2'h1, 8'he0, 8'hf8);
        bus(1'b1, 2'h0, 8'h00, 8'h00);
        bus(1'b0, 2'h0, 8'he0, 8'hff);
        settle();
        check(pins, 8'h50);
        bus(1'b1, 2'h0, 8'h10, 8'h00);
        repeat (4) @(posedge clk_in);
        check(pins, 8'h50);
        bus(1'b1, 2'h0, 8'h18, 8'h00);
        bus(1'b0, 2'h0, 8'hf0, 8'hff);
        run <= 1'b1;
        settle();
        bus(1'b1, 2'h0, 8'h10, 8'h00);
        repeat (4) @(posedge clk_in);
        check(pins, 8'h7a);
        check({7'h0, seen_ext}, 8'h01);
        check({7'h0, seen_osc}, 8'h01);
        bus(1'b0, 2'h1, 8'hb0, 8'hf8);
        // second life: pins left alone by an internal first write
        do_reset();
        x = 8'($random(seed));
        bus(1'b1, 2'h0, {x[7:5], 2'b01, x[2:1], 1'b0}, 8'h00);
        settle();
        check(pins, {1'b1, x[7], 3'b000, 1'b0, 2'b01});
        bus(1'b1, 2'h0, {~x[7:5], 2'b10, x[2:1], 1'b0}, 8'h00);
        bus(1'b0, 2'h0, {x[7:5], 2'b01, x[2:1], 1'b0}, 8'hff);
        check({7'h0, seen_ext}, 8'h00);
        check({7'h0, seen_osc}, 8'h00);
        // third life: bypassed crystal, off-mode oscillator control
        do_reset();
        startup <= 4'h0;
        bus(1'b1, 2'h0, 8'h30, 8'h00);
        settle();
        check(pins, 8'h1a);
        check({1'b0, prescale}, 8'h40);
        off_mode_in <= 1'b1;
        enable_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        check({7'h0, osc_en}, 8'h01);
        enable_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        check({7'h0, osc_en}, 8'h00);
        bus(1'b1, 2'h0, 8'h34, 8'h00);
        repeat (4) @(posedge clk_in);
        check({7'h0, osc_en}, 8'h01);
        bus(1'b0, 2'h0, 8'h34, 8'hff);
        off_mode_in <= 1'b0;
        bus(1'b1, 2'h2, 8'h00, 8'h00);
        give_verdict();
    end
endmodule
